/* src/lfdm_pkg.sv */
package lfdm_pkg;
	localparam int ROWS = 6;
	localparam int CLK_HZ = 40000000;
	// short-LED masking interval, in milliseconds
	localparam int SHORT_MASK_MS = 100;
	localparam int SHORT_MASK_CYC = (CLK_HZ / 1000) * SHORT_MASK_MS;
	// least brightness on pulse the host should give, microseconds (far side)
	localparam int MIN_ON_US = 10;
	// thermal trip and recovery hysteresis, degrees
	localparam int TEMP_TRIP_C = 150;
	localparam int TEMP_HYST_C = 30;
	localparam int MASK_W = 23;
	// apb register map
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_ROWS = 8'h08;
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_POLICY_BIT = 1;
	localparam logic [1:0] CTRL_RESET = 2'h0;
	localparam int ST_STARTUP_BIT = 0;
	localparam int ST_RUN_BIT = 1;
	localparam int ST_LATCH_BIT = 2;
	localparam int ST_OT_BIT = 3;
	localparam int ST_OC_BIT = 4;
	localparam int ST_ALARM_BIT = 5;

	typedef enum logic [1:0] {LFDM_OFF, LFDM_START, LFDM_RUN, LFDM_LATCHED} lfdm_state_t;

	// comparator inputs from the analog front end
	typedef struct packed {
		logic over_temp;
		logic temp_recovered;
		logic over_current;
		logic over_voltage;
		logic startup_done;
		logic [ROWS-1:0] row_high;
	} lfdm_cmp_t;

	typedef struct packed {
		logic row_sink_en_all;
		logic boost_en;
		logic power_switch_en;
		logic regulator_en;
		logic alarm_oe;
	} lfdm_drv_t;
endpackage

/* src/lfdm_manager.sv */
// Implementation choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
// Overview of operation
// [R1] over-temperature stops logic and boost, alarm low, regulator stays on
// [R2] over-temperature recovery is automatic once the recovered indication rises
// [R3] after start-up, row sinks follow the brightness input level
// [R4] brightness off phase pauses boost and turns all row sinks off
// [R5] during start-up the brightness input is ignored, duty forced full on
// [R6] host keeps brightness on pulses at least ten microseconds long
// [R7] short protection stays idle until start-up ends, then rows are watched for shorts
// [R8] alarm is an active-low open-collector output
// [R9] policy select is a static level choosing one of two fault behaviours
// [R10] over-current turns the power switch off, alarm stays high
// [R11] output over-voltage raises alarm, shuts down and latches
// [R12] policy low: row above short threshold after masking shuts down and latches
// [R13] short trip needs the row high continuously longer than the masking time
// [R14] policy high: short protection off, regulation continues, alarm untouched
// [R15] policy high: open row is excluded, alarm high, other rows go on
// [R16] policy low: first open row raises alarm, shuts down and latches
// [R17] latched shutdown clears only on enable toggle or power-on reset
// [R18] power-on reset comes from regulator undervoltage fall then rise
// [R19] host holds policy high when fewer than six rows are fitted
// [R20] open row declared when output reaches the floating-row limit
// [R21] comparator inputs are synchronised; power-on reset clears latched faults
module lfdm_manager import lfdm_pkg::*; #(
	parameter int MASK_CYC = SHORT_MASK_CYC
) (
	// clock and power-on reset
	input wire logic sys_clk,
	input wire logic nrst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// pins
	input wire logic brightness_pwm_in,
	input wire lfdm_cmp_t cmp_in,
	// drive outputs
	output lfdm_drv_t drv,
	output logic [ROWS-1:0] row_sink_en,
	output logic alarm_n_out
);
	typedef struct packed {
		lfdm_cmp_t cmp_s1;
		lfdm_cmp_t cmp_s2;
		logic pwm_s1;
		logic pwm_s2;
		logic [1:0] ctrl;
		logic en_prev;
		lfdm_state_t st;
		logic ot_active;
		logic oc_active;
		logic [ROWS-1:0] excluded;
		logic [ROWS*MASK_W-1:0] mask_cnt;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		lfdm_drv_t drv;
		logic [ROWS-1:0] row_en;
		logic alarm_n;
	} lfdm_regs_t;

	lfdm_regs_t s_reg;
	lfdm_regs_t s_next;

	function automatic logic [31:0] rd_mux(input logic [7:0] a, input lfdm_regs_t s);
		logic [31:0] r;
		r = 32'h0;
		case (a)
			OFS_CTRL: r[1:0] = s.ctrl;
			OFS_STATUS: begin
				r[ST_STARTUP_BIT] = (s.st == LFDM_START);
				r[ST_RUN_BIT] = (s.st == LFDM_RUN);
				r[ST_LATCH_BIT] = (s.st == LFDM_LATCHED);
				r[ST_OT_BIT] = s.ot_active;
				r[ST_OC_BIT] = s.oc_active;
				r[ST_ALARM_BIT] = ~s.alarm_n;
			end
			OFS_ROWS: r[ROWS-1:0] = s.excluded;
			default: r = 32'h0;
		endcase
		return r;
	endfunction

	function automatic logic addr_ok(input logic [7:0] a);
		return (a == OFS_CTRL) || (a == OFS_STATUS) || (a == OFS_ROWS);
	endfunction

	always_comb begin
		logic en;
		logic policy_high;
		logic en_rise;
		logic en_fall;
		logic latch_fault;
		logic [MASK_W-1:0] c;
		logic pwm_on;
		en = 1'b0;
		policy_high = 1'b0;
		en_rise = 1'b0;
		en_fall = 1'b0;
		latch_fault = 1'b0;
		c = '0;
		pwm_on = 1'b0;
		s_next = s_reg;
		// two-stage synchronisers on every pin input
		s_next.cmp_s1 = cmp_in; // R21
		s_next.cmp_s2 = s_reg.cmp_s1;
		s_next.pwm_s1 = brightness_pwm_in;
		s_next.pwm_s2 = s_reg.pwm_s1;
		// apb: single wait-free access, answered in the access phase
		s_next.pready = 1'b0;
		s_next.pslverr = 1'b0;
		if (psel && !penable) begin
			s_next.pready = 1'b1;
			s_next.pslverr = !addr_ok(paddr);
			s_next.prdata = rd_mux(paddr, s_reg);
		end
		if (psel && penable && s_reg.pready && pwrite && (paddr == OFS_CTRL)) begin
			s_next.ctrl = pwdata[1:0];
		end
		en = s_reg.ctrl[CTRL_EN_BIT];
		// policy is treated as a static strap level
		policy_high = s_reg.ctrl[CTRL_POLICY_BIT]; // R9
		s_next.en_prev = en;
		en_rise = en && !s_reg.en_prev;
		en_fall = !en && s_reg.en_prev;
		// thermal: trips in any state, clears only on recovered level
		if (s_reg.cmp_s2.over_temp) begin
			s_next.ot_active = 1'b1; // R1
		end else if (s_reg.cmp_s2.temp_recovered) begin
			s_next.ot_active = 1'b0; // R2
		end
		s_next.oc_active = s_reg.cmp_s2.over_current; // R10
		latch_fault = 1'b0;
		for (int i = 0; i < ROWS; i++) begin
			c = s_reg.mask_cnt[i*MASK_W +: MASK_W];
			// masking counter restarts whenever the row drops below threshold
			if (s_reg.st == LFDM_RUN && !policy_high && s_reg.cmp_s2.row_high[i] && !s_reg.excluded[i]) begin // R7 R14
				if (c < MASK_W'(MASK_CYC)) begin
					c = c + MASK_W'(1); // R13
				end else begin
					latch_fault = 1'b1; // R12
				end
			end else begin
				c = '0;
			end
			s_next.mask_cnt[i*MASK_W +: MASK_W] = c;
		end
		if (s_reg.st == LFDM_RUN && s_reg.cmp_s2.over_voltage) begin
			latch_fault = 1'b1; // R11
		end
		// floating-row limit reached during start-up excludes starved rows (policy high) or latches (policy low)
		if (s_reg.st == LFDM_START && s_reg.cmp_s2.over_voltage) begin // R20
			if (policy_high) begin
				s_next.excluded = s_reg.excluded | ~s_reg.cmp_s2.row_high; // R15
			end else begin
				latch_fault = 1'b1; // R16
			end
		end
		case (s_reg.st)
			LFDM_OFF: begin
				if (en) begin
					s_next.st = LFDM_START;
					s_next.excluded = '0;
				end
			end
			LFDM_START: begin
				if (!en) s_next.st = LFDM_OFF;
				else if (latch_fault) s_next.st = LFDM_LATCHED;
				else if (s_reg.cmp_s2.startup_done) s_next.st = LFDM_RUN;
			end
			LFDM_RUN: begin
				if (!en) s_next.st = LFDM_OFF;
				else if (latch_fault) s_next.st = LFDM_LATCHED;
			end
			LFDM_LATCHED: begin
				if (en_fall || en_rise) s_next.st = LFDM_OFF; // R17
			end
			default: s_next.st = LFDM_OFF;
		endcase
		pwm_on = (s_reg.st == LFDM_START) ? 1'b1 : s_reg.pwm_s2; // R5 R3
		s_next.drv.regulator_en = 1'b1;
		s_next.drv.power_switch_en = !s_reg.oc_active; // R10
		if ((s_reg.st == LFDM_START || s_reg.st == LFDM_RUN) && !s_reg.ot_active) begin
			s_next.drv.boost_en = pwm_on; // R4
			s_next.row_en = pwm_on ? ~s_reg.excluded : '0; // R3 R4 R15
		end else begin
			s_next.drv.boost_en = 1'b0; // R1
			s_next.row_en = '0;
		end
		s_next.drv.row_sink_en_all = |s_next.row_en;
		// open collector: alarm low means the pin is driven
		s_next.alarm_n = !(s_reg.ot_active || s_reg.st == LFDM_LATCHED); // R8 R1
		s_next.drv.alarm_oe = !s_next.alarm_n;
	end

	// nrst is the power-on reset from the regulator undervoltage detector
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			s_reg <= '0; // R18 R21
		end else begin
			s_reg <= s_next;
		end
	end

	assign prdata = s_reg.prdata;
	assign pready = s_reg.pready;
	assign pslverr = s_reg.pslverr;
	assign drv = s_reg.drv;
	assign row_sink_en = s_reg.row_en;
	assign alarm_n_out = s_reg.alarm_n;

	// thermal, supply and reset
	a_ot_alarm: assert property (@(posedge sys_clk) disable iff (!nrst) // R1
		s_reg.ot_active |=> !alarm_n_out && !drv.boost_en)
		else $error("thermal alarm missing");
	a_ot_regulator: assert property (@(posedge sys_clk) disable iff (!nrst) // R1
		$past(nrst) |-> drv.regulator_en)
		else $error("regulator dropped");
	a_ot_recover: assert property (@(posedge sys_clk) disable iff (!nrst) // R2
		(!s_reg.cmp_s2.over_temp && s_reg.cmp_s2.temp_recovered) |=> !s_reg.ot_active)
		else $error("thermal shutdown not released");
	a_reset_clear: assert property (@(posedge sys_clk) disable iff (!nrst) // R18 R21
		!$past(nrst) |-> s_reg.st == LFDM_OFF)
		else $error("state kept across power-on reset");
	a_sync_delay: assert property (@(posedge sys_clk) disable iff (!nrst) // R21
		($past(nrst) && $past(nrst, 2)) |-> s_reg.cmp_s2 == $past(cmp_in, 2))
		else $error("comparator sync path wrong");

	// dimming
	a_startup_full: assert property (@(posedge sys_clk) disable iff (!nrst) // R5
		(s_reg.st == LFDM_START && !s_reg.ot_active) |=> drv.boost_en)
		else $error("start-up not full on");
	a_pwm_off_rows: assert property (@(posedge sys_clk) disable iff (!nrst) // R4
		(s_reg.st == LFDM_RUN && !s_reg.pwm_s2) |=> row_sink_en == '0 && !drv.boost_en)
		else $error("rows on in off phase");
	a_rows_follow: assert property (@(posedge sys_clk) disable iff (!nrst) // R3
		(s_reg.st == LFDM_RUN && !s_reg.ot_active && s_reg.pwm_s2) |=> row_sink_en == ~$past(s_reg.excluded))
		else $error("rows not following brightness");
	a_row_all: assert property (@(posedge sys_clk) disable iff (!nrst) // R3
		1'b1 |-> drv.row_sink_en_all == |row_sink_en)
		else $error("row summary wrong");

	// boost protections
	a_oc_switch: assert property (@(posedge sys_clk) disable iff (!nrst) // R10
		s_reg.cmp_s2.over_current |=> ##1 !drv.power_switch_en)
		else $error("switch not off");
	a_oc_recover: assert property (@(posedge sys_clk) disable iff (!nrst) // R10
		!s_reg.cmp_s2.over_current |=> ##1 drv.power_switch_en)
		else $error("switch not back on");
	a_oc_alarm_high: assert property (@(posedge sys_clk) disable iff (!nrst) // R10
		(s_reg.cmp_s2.over_current && !s_reg.ot_active && s_reg.st != LFDM_LATCHED) |=> alarm_n_out)
		else $error("over-current pulled alarm");
	a_ov_latch: assert property (@(posedge sys_clk) disable iff (!nrst) // R11
		(s_reg.st == LFDM_RUN && en_live() && s_reg.cmp_s2.over_voltage) |=> s_reg.st == LFDM_LATCHED)
		else $error("over-voltage not latched");
	a_alarm_oe: assert property (@(posedge sys_clk) disable iff (!nrst) // R8
		$past(nrst) |-> drv.alarm_oe == !alarm_n_out)
		else $error("alarm enable disagrees with alarm");

	// row faults and latch
	a_short_latch: assert property (@(posedge sys_clk) disable iff (!nrst) // R12
		(s_reg.st == LFDM_RUN && en_live() && !s_reg.ctrl[CTRL_POLICY_BIT] && s_reg.cmp_s2.row_high[0] &&
		!s_reg.excluded[0] && s_reg.mask_cnt[0 +: MASK_W] == MASK_W'(MASK_CYC)) |=> s_reg.st == LFDM_LATCHED)
		else $error("short not latched");
	a_short_mask: assert property (@(posedge sys_clk) disable iff (!nrst) // R13
		!s_reg.cmp_s2.row_high[0] |=> s_reg.mask_cnt[0 +: MASK_W] == '0)
		else $error("mask time not restarted");
	a_policy_short_off: assert property (@(posedge sys_clk) disable iff (!nrst) // R14
		s_reg.ctrl[CTRL_POLICY_BIT] |=> s_reg.mask_cnt == '0)
		else $error("short timing with policy high");
	a_startup_no_short: assert property (@(posedge sys_clk) disable iff (!nrst) // R7
		(s_reg.st != LFDM_RUN) |=> s_reg.mask_cnt == '0)
		else $error("short timing outside run");
	a_open_exclude: assert property (@(posedge sys_clk) disable iff (!nrst) // R15 R20
		(s_reg.st == LFDM_START && s_reg.ctrl[CTRL_POLICY_BIT] && s_reg.cmp_s2.over_voltage) |=>
		(~$past(s_reg.cmp_s2.row_high) & ~s_reg.excluded) == '0) else $error("open row not excluded");
	a_open_alarm_high: assert property (@(posedge sys_clk) disable iff (!nrst) // R15
		(s_reg.st == LFDM_START && s_reg.ctrl[CTRL_POLICY_BIT] && !s_reg.ot_active) |=> alarm_n_out)
		else $error("open row pulled alarm");
	a_open_latch: assert property (@(posedge sys_clk) disable iff (!nrst) // R16
		(s_reg.st == LFDM_START && en_live() && !s_reg.ctrl[CTRL_POLICY_BIT] && s_reg.cmp_s2.over_voltage) |=>
		s_reg.st == LFDM_LATCHED) else $error("open row not latched");
	a_latch_hold: assert property (@(posedge sys_clk) disable iff (!nrst) // R17
		(s_reg.st == LFDM_LATCHED && $stable(s_reg.ctrl[CTRL_EN_BIT])) |=> s_reg.st == LFDM_LATCHED)
		else $error("latch left without toggle");
	a_latch_alarm: assert property (@(posedge sys_clk) disable iff (!nrst) // R16
		s_reg.st == LFDM_LATCHED |=> !alarm_n_out)
		else $error("latched without alarm");
	a_latch_rows: assert property (@(posedge sys_clk) disable iff (!nrst) // R16
		s_reg.st == LFDM_LATCHED |=> row_sink_en == '0 && !drv.boost_en)
		else $error("latched but still driving");
	a_excl_rows: assert property (@(posedge sys_clk) disable iff (!nrst) // R15
		(s_reg.st == LFDM_RUN) |=> (row_sink_en & $past(s_reg.excluded)) == '0)
		else $error("excluded row driven");

	function automatic logic en_live();
		return s_reg.ctrl[CTRL_EN_BIT];
	endfunction
endmodule

/* tb/lfdm_host_model.sv */
`timescale 1ns/1ps
module lfdm_host_model import lfdm_pkg::*; #(
	parameter int ON_CYC = MIN_ON_US * (CLK_HZ / 1000000)
) (
	// clock and mode
	input wire logic sys_clk,
	input wire logic run,
	input wire logic lvl,
	// brightness pin
	output logic brightness_pwm_in
);
	int cnt = 0;
	initial brightness_pwm_in = 1'b0;
	// free run keeps every on pulse at the minimum on time
	always @(posedge sys_clk) begin
		if (!run) begin
			brightness_pwm_in <= lvl;
			cnt <= 0;
		end else if (cnt >= ON_CYC - 1) begin
			brightness_pwm_in <= !brightness_pwm_in;
			cnt <= 0;
		end else begin
			cnt <= cnt + 1;
		end
	end
endmodule

/* tb/led_fault_dimming_manager_test.sv */
`timescale 1ns/1ps
module led_fault_dimming_manager_test import lfdm_pkg::*; ;
	localparam logic [31:0] M_LAT = 32'h1 << ST_LATCH_BIT;
	localparam logic [31:0] M_ST = 32'h1 << ST_STARTUP_BIT;
	logic sys_clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, run = 0, lvl = 0;
	logic [7:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata;
	logic pready, pslverr, pwm, alarm_n_out;
	lfdm_cmp_t cmp = '0;
	lfdm_drv_t drv;
	logic [ROWS-1:0] rows;
	int fail_count = 0, checks_done = 0, cycles = 0;
	always #12.5 sys_clk = !sys_clk;
	lfdm_manager #(.MASK_CYC(20)) DUT (.sys_clk(sys_clk), .nrst(nrst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.brightness_pwm_in(pwm), .cmp_in(cmp), .drv(drv), .row_sink_en(rows), .alarm_n_out(alarm_n_out));
	lfdm_host_model host (.sys_clk(sys_clk), .run(run), .lvl(lvl), .brightness_pwm_in(pwm));
	task give_verdict;
		if (fail_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// a hung handshake or pin wait lands here
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			fail_count++;
			give_verdict();
		end
	end
	task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask
	task tick(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	// one apb transfer; reads compare the masked word, every transfer its error flag
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m, input logic [31:0] x);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1;
		do @(posedge sys_clk); while (pready !== 1'b1);
		if (!w) chk("prdata", x, prdata & m);
		chk("pslverr", {31'h0, !(a inside {OFS_CTRL, OFS_STATUS, OFS_ROWS})}, {31'h0, pslverr});
		psel <= 0;
		penable <= 0;
		@(posedge sys_clk);
	endtask
	initial begin
		tick(8);
		nrst <= 1;
		tick(1);
		apb(0, OFS_CTRL, 0, 32'h3, {30'h0, CTRL_RESET});
		apb(0, 8'h0c, 0, '1, 0);
		cmp.row_high <= 6'h3f;
		apb(1, OFS_CTRL, 1, 0, 0);
		tick(30);
		chk("rows", 6'h3f, rows);
		apb(0, OFS_STATUS, 0, M_LAT | M_ST, M_ST);
		cmp.startup_done <= 1;
		cmp.row_high <= 0;
		tick(6);
		chk("rows", 0, rows);
		chk("boost", 0, drv.boost_en);
		lvl <= 1;
		tick(6);
		chk("rows", 6'h3f, rows);
		chk("boost", 1, drv.boost_en);
		// two short bursts below the mask must not add up
		cmp.row_high[0] <= 1;
		tick(12);
		cmp.row_high[0] <= 0;
		tick(2);
		cmp.row_high[0] <= 1;
		tick(12);
		cmp.row_high[0] <= 0;
		tick(6);
		apb(0, OFS_STATUS, 0, M_LAT, 0);
		cmp.row_high[0] <= 1;
		tick(30);
		chk("alarm", 0, alarm_n_out);
		chk("rows", 0, rows);
		apb(0, OFS_STATUS, 0, M_LAT, M_LAT);
		cmp.row_high[0] <= 0;
		apb(1, OFS_CTRL, 0, 0, 0);
		apb(1, OFS_CTRL, 1, 0, 0);
		tick(6);
		apb(0, OFS_STATUS, 0, M_LAT, 0);
		chk("alarm", 1, alarm_n_out);
		cmp.over_current <= 1;
		tick(6);
		chk("switch", 0, drv.power_switch_en);
		chk("alarm", 1, alarm_n_out);
		cmp.over_current <= 0;
		cmp.over_temp <= 1;
		tick(6);
		chk("boost", 0, drv.boost_en);
		chk("regulator", 1, drv.regulator_en);
		chk("alarm", 0, alarm_n_out);
		chk("alarm_oe", 1, drv.alarm_oe);
		cmp.over_temp <= 0;
		cmp.temp_recovered <= 1;
		tick(6);
		chk("boost", 1, drv.boost_en);
		chk("alarm", 1, alarm_n_out);
		cmp.temp_recovered <= 0;
		run <= 1;
		@(negedge pwm);
		tick(6);
		chk("rows", 0, rows);
		@(posedge pwm);
		tick(6);
		chk("rows", 6'h3f, rows);
		cmp.over_voltage <= 1;
		tick(6);
		chk("alarm", 0, alarm_n_out);
		apb(0, OFS_STATUS, 0, M_LAT, M_LAT);
		cmp.over_voltage <= 0;
		nrst <= 0;
		tick(2);
		nrst <= 1;
		tick(2);
		apb(0, OFS_STATUS, 0, M_LAT, 0);
		run <= 0;
		cmp.startup_done <= 0;
		cmp.row_high <= 6'h0f;
		apb(1, OFS_CTRL, 3, 0, 0);
		tick(6);
		cmp.over_voltage <= 1;
		tick(6);
		cmp.over_voltage <= 0;
		apb(0, OFS_ROWS, 0, 32'h3f, 32'h30);
		chk("alarm", 1, alarm_n_out);
		cmp.startup_done <= 1;
		cmp.row_high <= 6'h01;
		tick(30);
		chk("rows", 6'h0f, rows);
		chk("alarm", 1, alarm_n_out);
		cmp.startup_done <= 0;
		cmp.row_high <= 6'h0f;
		apb(1, OFS_CTRL, 0, 0, 0);
		apb(1, OFS_CTRL, 1, 0, 0);
		tick(6);
		cmp.over_voltage <= 1;
		tick(6);
		chk("alarm", 0, alarm_n_out);
		apb(0, OFS_STATUS, 0, M_LAT, M_LAT);
		give_verdict();
	end
endmodule
